// ===== core/cswd_pkg.sv
// package: register map, field layout and timing constants of the wake decoder
package cswd_pkg;
   //--------------------------------------------------
   // register byte offsets
   //--------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_OSCH = 8'h04;
   localparam logic [7:0] A_OSCL = 8'h08;
   localparam logic [7:0] A_TRIM = 8'h0C;
   localparam logic [7:0] A_OPT = 8'h10;
   localparam logic [7:0] A_FLT = 8'h14;
   localparam logic [7:0] A_BQ = 8'h18;
   localparam logic [7:0] A_SPP = 8'h1C;
   localparam logic [7:0] A_UL = 8'h20;
   localparam logic [7:0] A_LL = 8'h24;
   localparam logic [7:0] A_STAT = 8'h28;
   //--------------------------------------------------
   // control and status field positions
   //--------------------------------------------------
   localparam int F_MEAS = 0;
   localparam int F_TRIM = 1;
   localparam int F_FDEN = 3;
   localparam int F_DIS = 4;
   localparam int F_CDR = 5;
   localparam int F_SEL = 6;
   localparam int S_WAKE = 0;
   localparam int S_FRM = 1;
   localparam int S_SYS = 2;
   localparam int S_ERROR_COUNT_FIELD = 3;
   localparam int S_BLEN = 16;
   //--------------------------------------------------
   // reset values
   //--------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] TRIM_RST = 8'h80;
   localparam logic [7:0] OPT_RST = 8'h00;
   localparam logic [7:0] FLT_RST = 8'h04;
   localparam logic [7:0] BQ_RST = 8'h28;
   localparam logic [5:0] SPP_RST = 6'h33;
   localparam logic [7:0] UL_RST = 8'h30;
   localparam logic [7:0] LL_RST = 8'h20;
   //--------------------------------------------------
   // protocol and timing constants
   //--------------------------------------------------
   localparam logic [1:0] TRIM_ON = 2'h3;
   localparam logic [3:0] IDLE_LAST = 4'h6;
   localparam logic [6:0] HDR_LAST = 7'h0D;
   localparam logic [6:0] RTR_POS = 7'h0C;
   localparam logic [6:0] DLC_LAST = 7'h03;
   localparam logic [6:0] CRC_LAST = 7'h0E;
   localparam logic [2:0] STUFF_RUN = 3'h5;
   localparam logic [5:0] ERROR_COUNT_FIELD_OVF = 6'h20;
   localparam logic [14:0] CRC_POLY = 15'h4599;
   localparam int CLK_HZ = 20000000;
   localparam int SILENCE_MS = 900;
   localparam int SILENCE_CYC = (CLK_HZ / 1000) * SILENCE_MS;
   //--------------------------------------------------
   // decoder states
   //--------------------------------------------------
   typedef enum logic [2:0] {
      ST_WAIT, ST_READY, ST_HDR, ST_EDL, ST_DLC, ST_DATA, ST_CRC, ST_DELIM
   } cswd_state_t;
endpackage

// ===== core/cswd_top.sv
// selective-wake frame decoder: oscillator measure, fd tolerance, error count, clock recovery
// Function
// - count transmit-input pulse, readable in count registers
// - tolerant mode skips fd frame high-rate part
// - no stuff, crc, form checks on fd
// - fd frames wake only through error counter overflow, with tolerant off
// - ready again after fd frame end-of-frame
// - edl bit one means fd, zero classic
// - programmable filter sets minimum dominant data bit
// - tolerant off: count up errors, down good
// - tolerant on, disable off: down on all good
// - tolerant and disable set: counter held zero
// - silence timeout clears counter disable bit
// - recovery measures bits and adjusts bit length
// - limit reached: drop estimate, reload programmed timing
// - new start accepted after recessive idle bits
// - filter rejects short glitches at 2 mbit
// - filter rejects short glitches at 5 mbit
// - wake signalled within 100 microseconds
// - wake sets flag and reports wake details
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cswd_top #(
   parameter int SILENCE_CYC = cswd_pkg::SILENCE_CYC
) (
   input wire logic clock, // 20 mhz system clock
   input wire logic reset, // synchronous, active high
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write enable
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte enables
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic can_rx_pin, // bus receive level, low dominant
   input wire logic can_transmit_input, // calibration pulse pin, low active
   input wire logic frame_match, // id and data matcher verdict
   output logic wake_event, // one-cycle wake pulse
   output logic [7:0] osc_trim_out, // oscillator trim value
   output logic [7:0] option_out // wake option control value
);
   //--------------------------------------------------
   // pin synchronisers
   //--------------------------------------------------
   logic rx_meta_reg, rx_reg, rx_prev_reg;
   logic tx_meta_reg, tx_reg, tx_prev_reg;
   logic fall, edge_seen;

   // two flops per pin, third stage for edges
   always_ff @(posedge clock) begin
      if (reset) begin
         rx_meta_reg <= 1'b1;
         rx_reg <= 1'b1;
         rx_prev_reg <= 1'b1;
         tx_meta_reg <= 1'b1;
         tx_reg <= 1'b1;
         tx_prev_reg <= 1'b1;
      end else begin
         rx_meta_reg <= can_rx_pin;
         rx_reg <= rx_meta_reg;
         rx_prev_reg <= rx_reg;
         tx_meta_reg <= can_transmit_input;
         tx_reg <= tx_meta_reg;
         tx_prev_reg <= tx_reg;
      end
   end

   assign fall = rx_prev_reg & ~rx_reg;
   assign edge_seen = rx_prev_reg ^ rx_reg;

   //--------------------------------------------------
   // declarations
   //--------------------------------------------------
   logic [7:0] ctrl_reg, ctrl_next, trim_reg, trim_next, opt_reg, opt_next;
   logic [7:0] flt_reg, flt_next, bq_reg, bq_next, ul_reg, ul_next, ll_reg, ll_next;
   logic [5:0] spp_reg, spp_next;
   logic ack_reg, ack_next, wake_reg, wake_next, frm_reg, frm_next;
   logic sys_reg, sys_next, wev_reg, wev_next;
   logic [31:0] dat_reg, dat_next, rdata;
   logic [15:0] ocnt_reg, ocnt_next, olat_reg, olat_next;
   cswd_pkg::cswd_state_t st_reg, st_next;
   logic [9:0] cyc_reg, cyc_next, ecyc_reg, ecyc_next, bitc, spt;
   logic [6:0] cnt_reg, cnt_next, dlim;
   logic [2:0] run_reg, run_next;
   logic last_reg, last_next, stp_reg, stp_next, rtr_reg, rtr_next;
   logic fd_reg, fd_next, fdp_reg, fdp_next;
   logic [14:0] crc_reg, crc_next;
   logic [3:0] dlc_reg, dlc_next, dlcn, idle_reg, idle_next;
   logic [7:0] dom_reg, dom_next, blen_reg, blen_next, thr, q;
   logic [5:0] error_count_field_reg, error_count_field_next;
   logic [24:0] sil_reg, sil_next;
   logic [15:0] prod;
   logic [8:0] hi, d, nb;
   logic infrm, samp, good, bad, fddone, ovf, sil_exp, wake_set, wr, trim_ok, b;

   //--------------------------------------------------
   // oscillator pulse measurement
   //--------------------------------------------------
   // count cycles while the pin is low, latch at the rising edge
   always_comb begin
      ocnt_next = ocnt_reg;
      olat_next = olat_reg;
      if (ctrl_reg[cswd_pkg::F_MEAS]) begin
         if (tx_prev_reg & ~tx_reg) begin
            ocnt_next = 16'h0001;
         end else if (~tx_reg && ocnt_reg != 16'hFFFF) begin
            ocnt_next = ocnt_reg + 16'h0001;
         end
         if (~tx_prev_reg & tx_reg) begin
            olat_next = ocnt_reg;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ocnt_reg <= 16'h0000;
         olat_reg <= 16'h0000;
      end else begin
         ocnt_reg <= ocnt_next;
         olat_reg <= olat_next;
      end
   end

   //--------------------------------------------------
   // frame decoder, recovery, error counter
   //--------------------------------------------------
   // bit length, sample point and decode sequence
   always_comb begin
      st_next = st_reg;
      cyc_next = cyc_reg + 10'h001;
      cnt_next = cnt_reg;
      run_next = run_reg;
      last_next = last_reg;
      stp_next = stp_reg;
      rtr_next = rtr_reg;
      fd_next = fd_reg;
      fdp_next = fdp_reg;
      crc_next = crc_reg;
      dlc_next = dlc_reg;
      idle_next = idle_reg;
      dom_next = 8'h00;
      error_count_field_next = error_count_field_reg;
      blen_next = blen_reg;
      ecyc_next = (ecyc_reg == 10'h3FF) ? ecyc_reg : ecyc_reg + 10'h001;
      sil_next = sil_reg;
      good = 1'b0;
      bad = 1'b0;
      fddone = 1'b0;
      ovf = 1'b0;
      sil_exp = 1'b0;
      b = rx_reg;
      bitc = {2'b00, blen_reg} << ctrl_reg[cswd_pkg::F_SEL +: 2];
      prod = {6'h00, bitc} * {10'h000, spp_reg};
      spt = prod[15:6];
      infrm = (st_reg != cswd_pkg::ST_WAIT) && (st_reg != cswd_pkg::ST_READY);
      samp = infrm && !fall && (cyc_reg == spt);
      thr = fd_reg ? flt_reg : 8'h01;
      dlcn = {dlc_reg[2:0], b};
      dlim = dlc_reg[3] ? 7'h3F : {1'b0, dlc_reg[2:0], 3'b000} - 7'h01;
      q = 8'(ecyc_reg >> ctrl_reg[cswd_pkg::F_SEL +: 2]);
      hi = {1'b0, blen_reg} + {2'b00, blen_reg[7:1]};
      d = {1'b0, q} - {1'b0, blen_reg};
      nb = {1'b0, blen_reg} + {{2{d[8]}}, d[8:2]};
      // bus silence watchdog
      if (!rx_reg) begin
         sil_next = 25'h0000000;
      end else if (sil_reg != 25'(SILENCE_CYC)) begin
         sil_next = sil_reg + 25'h0000001;
         sil_exp = (sil_reg == 25'(SILENCE_CYC - 1));
      end
      // clock recovery on single-bit edge intervals
      if (!ctrl_reg[cswd_pkg::F_CDR]) begin
         blen_next = bq_reg;
      end
      if (edge_seen) begin
         ecyc_next = 10'h001; // start at one so q is the whole interval
         if (ctrl_reg[cswd_pkg::F_CDR] && infrm &&
             q > (blen_reg - {1'b0, blen_reg[7:1]}) && {1'b0, q} < hi) begin
            if (nb[8] || nb[7:0] >= ul_reg || nb[7:0] <= ll_reg) begin
               blen_next = bq_reg;
            end else begin
               blen_next = nb[7:0];
            end
         end
      end
      if (infrm && (fall || cyc_reg == bitc - 10'h001)) begin
         cyc_next = 10'h000;
      end
      unique case (st_reg)
         cswd_pkg::ST_WAIT: begin
            if (!rx_reg) begin
               dom_next = (dom_reg == 8'hFF) ? dom_reg : dom_reg + 8'h01;
               if ({1'b0, dom_reg} + 9'h001 >= {1'b0, thr}) begin
                  idle_next = 4'h0;
                  cyc_next = 10'h000;
               end
            end else if (cyc_reg >= bitc - 10'h001) begin
               cyc_next = 10'h000;
               idle_next = idle_reg + 4'h1;
               if (idle_reg == cswd_pkg::IDLE_LAST) begin
                  st_next = cswd_pkg::ST_READY;
                  fddone = fdp_reg;
                  fd_next = 1'b0;
                  fdp_next = 1'b0;
               end
            end
         end
         cswd_pkg::ST_READY: begin
            cyc_next = 10'h000;
            if (fall) begin
               st_next = cswd_pkg::ST_HDR;
               cnt_next = 7'h00;
               run_next = 3'h0;
               last_next = 1'b1;
               stp_next = 1'b0;
               crc_next = 15'h0000;
            end
         end
         default: begin
            if (samp && stp_reg) begin
               stp_next = 1'b0;
               last_next = b;
               run_next = 3'h1;
               bad = (b == last_reg);
            end else if (samp) begin
               cnt_next = cnt_reg + 7'h01;
               last_next = b;
               run_next = (b == last_reg) ? run_reg + 3'h1 : 3'h1;
               if (st_reg != cswd_pkg::ST_DELIM) begin
                  stp_next = (run_next == cswd_pkg::STUFF_RUN);
                  crc_next = {crc_reg[13:0], 1'b0} ^
                             ((b ^ crc_reg[14]) ? cswd_pkg::CRC_POLY : 15'h0000);
               end
               unique case (st_reg)
                  cswd_pkg::ST_HDR: begin
                     if (cnt_reg == cswd_pkg::RTR_POS) begin
                        rtr_next = b;
                     end
                     if (cnt_reg == cswd_pkg::HDR_LAST) begin
                        st_next = b ? cswd_pkg::ST_WAIT : cswd_pkg::ST_EDL;
                        cnt_next = 7'h00;
                     end
                  end
                  cswd_pkg::ST_EDL: begin
                     cnt_next = 7'h00;
                     if (!b) begin
                        st_next = cswd_pkg::ST_DLC;
                     end else if (ctrl_reg[cswd_pkg::F_FDEN]) begin
                        st_next = cswd_pkg::ST_WAIT;
                        fd_next = 1'b1;
                        fdp_next = 1'b1;
                     end else begin
                        bad = 1'b1;
                     end
                  end
                  cswd_pkg::ST_DLC: begin
                     dlc_next = dlcn;
                     if (cnt_reg == cswd_pkg::DLC_LAST) begin
                        cnt_next = 7'h00;
                        st_next = (rtr_reg || dlcn == 4'h0) ?
                                  cswd_pkg::ST_CRC : cswd_pkg::ST_DATA;
                     end
                  end
                  cswd_pkg::ST_DATA: begin
                     if (cnt_reg == dlim) begin
                        cnt_next = 7'h00;
                        st_next = cswd_pkg::ST_CRC;
                     end
                  end
                  cswd_pkg::ST_CRC: begin
                     if (cnt_reg == cswd_pkg::CRC_LAST) begin
                        st_next = cswd_pkg::ST_DELIM;
                     end
                  end
                  default: begin
                     good = b && (crc_reg == 15'h0000);
                     bad = !good;
                     st_next = cswd_pkg::ST_WAIT;
                  end
               endcase
            end
            if (bad) begin
               st_next = cswd_pkg::ST_WAIT;
               stp_next = 1'b0;
            end
            if (st_next == cswd_pkg::ST_WAIT) begin
               idle_next = 4'h0;
            end
         end
      endcase
      // error counter under tolerant and disable settings
      if (ctrl_reg[cswd_pkg::F_FDEN] && ctrl_reg[cswd_pkg::F_DIS]) begin
         error_count_field_next = 6'h00;
      end else if (bad && error_count_field_reg != cswd_pkg::ERROR_COUNT_FIELD_OVF) begin
         error_count_field_next = error_count_field_reg + 6'h01;
         ovf = (error_count_field_next == cswd_pkg::ERROR_COUNT_FIELD_OVF);
      end else if ((good || fddone) && error_count_field_reg != 6'h00) begin
         error_count_field_next = error_count_field_reg - 6'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st_reg <= cswd_pkg::ST_WAIT;
         cyc_reg <= 10'h000;
         cnt_reg <= 7'h00;
         run_reg <= 3'h0;
         last_reg <= 1'b1;
         stp_reg <= 1'b0;
         rtr_reg <= 1'b0;
         fd_reg <= 1'b0;
         fdp_reg <= 1'b0;
         crc_reg <= 15'h0000;
         dlc_reg <= 4'h0;
         idle_reg <= 4'h0;
         dom_reg <= 8'h00;
         error_count_field_reg <= 6'h00;
         blen_reg <= cswd_pkg::BQ_RST;
         ecyc_reg <= 10'h000;
         sil_reg <= 25'h0000000;
      end else begin
         st_reg <= st_next;
         cyc_reg <= cyc_next;
         cnt_reg <= cnt_next;
         run_reg <= run_next;
         last_reg <= last_next;
         stp_reg <= stp_next;
         rtr_reg <= rtr_next;
         fd_reg <= fd_next;
         fdp_reg <= fdp_next;
         crc_reg <= crc_next;
         dlc_reg <= dlc_next;
         idle_reg <= idle_next;
         dom_reg <= dom_next;
         error_count_field_reg <= error_count_field_next;
         blen_reg <= blen_next;
         ecyc_reg <= ecyc_next;
         sil_reg <= sil_next;
      end
   end

   //--------------------------------------------------
   // wishbone register file
   //--------------------------------------------------
   assign wake_set = (good && frame_match) || ovf;
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];
   assign trim_ok = ctrl_reg[cswd_pkg::F_MEAS] &&
                    ctrl_reg[cswd_pkg::F_TRIM +: 2] == cswd_pkg::TRIM_ON;

   // read mux
   always_comb begin
      rdata = 32'h00000000;
      unique case (wb_adr_i)
         cswd_pkg::A_CTRL: rdata[7:0] = ctrl_reg;
         cswd_pkg::A_OSCH: rdata[7:0] = olat_reg[15:8];
         cswd_pkg::A_OSCL: rdata[7:0] = olat_reg[7:0];
         cswd_pkg::A_TRIM: rdata[7:0] = trim_reg;
         cswd_pkg::A_OPT: rdata[7:0] = opt_reg;
         cswd_pkg::A_FLT: rdata[7:0] = flt_reg;
         cswd_pkg::A_BQ: rdata[7:0] = bq_reg;
         cswd_pkg::A_SPP: rdata[5:0] = spp_reg;
         cswd_pkg::A_UL: rdata[7:0] = ul_reg;
         cswd_pkg::A_LL: rdata[7:0] = ll_reg;
         cswd_pkg::A_STAT: begin
            rdata[cswd_pkg::S_WAKE] = wake_reg;
            rdata[cswd_pkg::S_FRM] = frm_reg;
            rdata[cswd_pkg::S_SYS] = sys_reg;
            rdata[cswd_pkg::S_ERROR_COUNT_FIELD +: 6] = error_count_field_reg;
            rdata[cswd_pkg::S_BLEN +: 8] = blen_reg;
         end
         default: rdata = 32'h00000000;
      endcase
   end

   // writes land on the edge that sees ack; status bits clear on write one
   always_comb begin
      ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
      dat_next = ack_next ? rdata : 32'h00000000;
      ctrl_next = ctrl_reg;
      trim_next = trim_reg;
      opt_next = opt_reg;
      flt_next = flt_reg;
      bq_next = bq_reg;
      spp_next = spp_reg;
      ul_next = ul_reg;
      ll_next = ll_reg;
      if (wr) begin
         unique case (wb_adr_i)
            cswd_pkg::A_CTRL: ctrl_next = wb_dat_i[7:0];
            cswd_pkg::A_TRIM: trim_next = trim_ok ? wb_dat_i[7:0] : trim_reg;
            cswd_pkg::A_OPT: opt_next = trim_ok ? wb_dat_i[7:0] : opt_reg;
            cswd_pkg::A_FLT: flt_next = wb_dat_i[7:0];
            cswd_pkg::A_BQ: bq_next = wb_dat_i[7:0];
            cswd_pkg::A_SPP: spp_next = wb_dat_i[5:0];
            cswd_pkg::A_UL: ul_next = wb_dat_i[7:0];
            cswd_pkg::A_LL: ll_next = wb_dat_i[7:0];
            default: ctrl_next = ctrl_reg;
         endcase
      end
      if (sil_exp) begin
         ctrl_next[cswd_pkg::F_DIS] = 1'b0;
      end
      wake_next = wr_clr(wake_reg, cswd_pkg::S_WAKE, wake_set);
      frm_next = wr_clr(frm_reg, cswd_pkg::S_FRM, good && frame_match);
      sys_next = wr_clr(sys_reg, cswd_pkg::S_SYS, ovf);
      wev_next = wake_set;
   end

   // sticky flag: set wins over a write-one clear
   function automatic logic wr_clr(input logic cur, input int pos, input logic set);
      return set | (cur & ~(wr && wb_adr_i == cswd_pkg::A_STAT && wb_dat_i[pos]));
   endfunction

   always_ff @(posedge clock) begin
      if (reset) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
         ctrl_reg <= cswd_pkg::CTRL_RST;
         trim_reg <= cswd_pkg::TRIM_RST;
         opt_reg <= cswd_pkg::OPT_RST;
         flt_reg <= cswd_pkg::FLT_RST;
         bq_reg <= cswd_pkg::BQ_RST;
         spp_reg <= cswd_pkg::SPP_RST;
         ul_reg <= cswd_pkg::UL_RST;
         ll_reg <= cswd_pkg::LL_RST;
         wake_reg <= 1'b0;
         frm_reg <= 1'b0;
         sys_reg <= 1'b0;
         wev_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
         dat_reg <= dat_next;
         ctrl_reg <= ctrl_next;
         trim_reg <= trim_next;
         opt_reg <= opt_next;
         flt_reg <= flt_next;
         bq_reg <= bq_next;
         spp_reg <= spp_next;
         ul_reg <= ul_next;
         ll_reg <= ll_next;
         wake_reg <= wake_next;
         frm_reg <= frm_next;
         sys_reg <= sys_next;
         wev_reg <= wev_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign wake_event = wev_reg;
   assign osc_trim_out = trim_reg;
   assign option_out = opt_reg;
endmodule // cswd_top

// ===== sim/cswd_asserts.sv
// checker: bus handshake, reset value and output stability assertions
`timescale 1ns/1ps
module cswd_asserts #(
   parameter int SILENCE_CYC = 2000
) (
   input wire logic clock, // clock
   input wire logic reset, // sync reset
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [7:0] wb_adr_i, // address
   input wire logic [3:0] wb_sel_i, // byte enables
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic [31:0] wb_dat_o, // read data
   input wire logic wb_ack_o, // acknowledge
   input wire logic can_rx_pin, // bus level
   input wire logic can_transmit_input, // pulse pin
   input wire logic frame_match, // matcher verdict
   input wire logic wake_event, // wake pulse
   input wire logic [7:0] osc_trim_out, // trim copy
   input wire logic [7:0] option_out // option copy
);
   //---------------------------------------------
   // properties
   //---------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_quiet;
      !wb_cyc_i ##1 !wb_cyc_i;
   endsequence
   property p_ack_lat;
      s_req |=> wb_ack_o;
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("late ack");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
   property p_ack_cause;
      $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
   property p_trim_rst;
      @(posedge clock) disable iff (1'b0)
      $fell(reset) |-> osc_trim_out == 8'h80 && option_out == 8'h00;
   endproperty
   a_trim_rst: assert property (p_trim_rst) else $error("bad reset copy");
   property p_trim_quiet;
      s_quiet |=> $stable(osc_trim_out);
   endproperty
   a_trim_quiet: assert property (p_trim_quiet) else $error("trim moved");
   property p_opt_quiet;
      s_quiet |=> $stable(option_out);
   endproperty
   a_opt_quiet: assert property (p_opt_quiet) else $error("option moved");
   property p_wake_pulse;
      wake_event |=> !wake_event;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("long wake");
endmodule // cswd_asserts

bind cswd_top cswd_asserts #(.SILENCE_CYC(SILENCE_CYC)) u_chk (.clock, .reset, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .can_rx_pin,
   .can_transmit_input, .frame_match, .wake_event, .osc_trim_out, .option_out);

// ===== sim/cswd_can_node.sv
// far-side bus node: plays a flexible-data-rate frame onto the receive line
`timescale 1ns/1ps
module cswd_can_node #(
   parameter int BIT_CLK = 40
) (
   input wire logic clock, // system clock
   output logic can_rx_pin // bus level, low dominant
);
   // sof, id 10101010101, rtr 0, ide 0, edl 1, then data-phase bits
   localparam logic [19:0] FD_BITS = 20'h5552C;
   // released bus rests recessive
   initial can_rx_pin = 1'b1;
   // idle, frame bits msb first, then idle past end of frame
   task automatic send_fd();
      repeat (10 * BIT_CLK) @(posedge clock);
      for (int i = 19; i >= 0; i--) begin
         can_rx_pin <= FD_BITS[i];
         repeat (BIT_CLK) @(posedge clock);
      end
      can_rx_pin <= 1'b1;
      repeat (10 * BIT_CLK) @(posedge clock);
   endtask
endmodule // cswd_can_node

// ===== sim/tb_top.sv
// testbench: registers, oscillator count, trimming and fd-tolerant error counting
`timescale 1ns/1ps
module tb_top;
   logic clock, reset, wb_cyc_i, wb_stb_i, wb_we_i, can_rx_pin, can_transmit_input, frame_match;
   logic [7:0] wb_adr_i, osc_trim_out, option_out;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic wb_ack_o, wake_event;
   int mismatches = 0;
   int cmp_count = 0;
   cswd_top #(.SILENCE_CYC(2000)) dut (.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .can_rx_pin, .can_transmit_input,
      .frame_match, .wake_event, .osc_trim_out, .option_out);
   cswd_can_node node (.clock, .can_rx_pin);
   //---------------------------------------------
   // bus and compare tasks
   //---------------------------------------------
   always #25 clock = ~clock;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] q);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge clock);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(nm, e, q);
   endtask
   // flags and error count in the low status bits
   task automatic st_chk(input logic [5:0] e);
      logic [31:0] q;
      wb(1'b0, cswd_pkg::A_STAT, 8'h00, q);
      chk("status", {23'h0, e, 3'h0}, {23'h0, q[8:0]});
   endtask
   //---------------------------------------------
   // scenarios
   //---------------------------------------------
   task automatic t_regs();
      rd_chk(cswd_pkg::A_CTRL, 32'h00, "ctrl");
      rd_chk(cswd_pkg::A_TRIM, 32'h80, "trim");
      rd_chk(cswd_pkg::A_FLT, 32'h04, "filter");
      rd_chk(cswd_pkg::A_BQ, 32'h28, "quanta");
      rd_chk(cswd_pkg::A_SPP, 32'h33, "sample point");
      rd_chk(cswd_pkg::A_UL, 32'h30, "upper limit");
      rd_chk(cswd_pkg::A_LL, 32'h20, "lower limit");
      rd_chk(8'h30, 32'h00, "unmapped");
   endtask
   task automatic t_osc();
      wr(cswd_pkg::A_CTRL, 8'h01);
      can_transmit_input <= 1'b0;
      repeat (37) @(posedge clock);
      can_transmit_input <= 1'b1;
      repeat (8) @(posedge clock);
      rd_chk(cswd_pkg::A_OSCL, 32'h25, "osc count low");
      rd_chk(cswd_pkg::A_OSCH, 32'h00, "osc count high");
   endtask
   task automatic t_trim();
      wr(cswd_pkg::A_TRIM, 8'h55);
      rd_chk(cswd_pkg::A_TRIM, 32'h80, "trim locked");
      wr(cswd_pkg::A_CTRL, 8'h07);
      wr(cswd_pkg::A_TRIM, 8'h55);
      wr(cswd_pkg::A_OPT, 8'h3C);
      rd_chk(cswd_pkg::A_TRIM, 32'h55, "trim value");
      chk("trim pins", 32'h553C, {16'h0, osc_trim_out, option_out});
      wr(cswd_pkg::A_CTRL, 8'h00);
      wr(cswd_pkg::A_OPT, 8'h11);
      rd_chk(cswd_pkg::A_OPT, 32'h3C, "option locked");
   endtask
   task automatic t_fd_count();
      node.send_fd();
      node.send_fd();
      st_chk(6'h02);
      wr(cswd_pkg::A_CTRL, 8'h08);
      frame_match <= 1'b1;
      node.send_fd();
      st_chk(6'h01);
      node.send_fd();
      st_chk(6'h00);
   endtask
   task automatic t_fd_clear();
      wr(cswd_pkg::A_CTRL, 8'h10);
      node.send_fd();
      st_chk(6'h01);
      wr(cswd_pkg::A_CTRL, 8'h18);
      st_chk(6'h00);
      node.send_fd();
      st_chk(6'h00);
      repeat (2100) @(posedge clock);
      rd_chk(cswd_pkg::A_CTRL, 32'h08, "disable cleared");
   endtask
   // recovery tracks the node bit length, then limit reload
   task automatic t_cdr();
      logic [31:0] q;
      wr(cswd_pkg::A_CTRL, 8'h08);
      wr(cswd_pkg::A_BQ, 8'h2C);
      wr(cswd_pkg::A_CTRL, 8'h28);
      node.send_fd();
      rd_chk(cswd_pkg::A_STAT, 32'h00280000, "tracked length");
      wr(cswd_pkg::A_CTRL, 8'h08);
      wr(cswd_pkg::A_UL, 8'h29);
      wr(cswd_pkg::A_CTRL, 8'h28);
      node.send_fd();
      wb(1'b0, cswd_pkg::A_STAT, 8'h00, q);
      chk("reloaded length", 32'h2C, {24'h0, q[23:16]});
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // main sequence after 12 reset cycles
   initial begin
      clock = 1'b0;
      reset = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, frame_match} = 4'h0;
      can_transmit_input = 1'b1;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_regs();
      t_osc();
      t_trim();
      t_fd_count();
      t_fd_clear();
      t_cdr();
      end_of_test();
   end
   // watchdog against a hung handshake
   initial begin
      repeat (40000) @(posedge clock);
      mismatches++;
      end_of_test();
   end
endmodule // tb_top
